// ---- dv/tb.sv ----
// Self-checking testbench for the watchdog top level
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wwdt_pkg::*;
  // Short tick keeps every period within a few thousand cycles
  localparam int D = 2;
  logic        core_clk, arst_n, reg_wr, reg_rd, ps_idle, rreq, wk, force_on, flag;
  logic [3:0]  reg_addr, evt;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [31:0] seed;
  int          error_cnt, checks, c, p;
  int          thr[4] = '{8, 16, 20, 24};

  wwdt_top #(.DIV(D)) u_wwdt_top (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .watchdog_clear_instruction(evt[0]), .power_save_instruction(evt[1]),
    .power_save_idle(ps_idle), .clock_switch_done(evt[2]), .wake_event(evt[3]),
    .wdt_reset_req(rreq), .wdt_wake(wk), .low_power_rc_oscillator_force_on(force_on), .timeout_flag(flag)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int per(input logic pre, input logic [1:0] post);
    return (pre ? 128 : 32) << post;
  endfunction
  task automatic results();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic ev(input logic [3:0] k);
    evt <= k;
    @(posedge core_clk);
    evt <= 4'h0;
  endtask
  task automatic watch(input int n, input bit must);
    c = 0;
    #1;
    while (!(rreq || wk) && c < n) begin
      @(posedge core_clk);
      #1 c++;
    end
    if (must && c >= n) begin
      error_cnt++;
      $display("[ERR] %0t no timeout seen", $time);
      results();
    end
  endtask

  initial begin
    #3000000;
    error_cnt++;
    results();
  end

  initial begin
    arst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    evt = 4'h0;
    ps_idle = 1'b0;
    seed = 32'hA266884F;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rd(WWDT_ADDR_CONFIG);
    check(d, CFG_RESET_VAL);
    rd(WWDT_ADDR_RESET);
    check(d, 16'h0000);
    rd(4'hF);
    check(d, 16'h0000);
    watch(200, 0);
    check({force_on, 7'h00, 8'(c)}, 16'h00C8);
    rd(WWDT_ADDR_COUNT);
    check(d, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      if (i < 2) seed[4:0] = i ? 5'h13 : 5'h00;
      p = per(seed[4], seed[1:0]);
      wr(WWDT_ADDR_CONFIG, {8'h00, 1'b1, EN_ALWAYS, seed[4], 2'b00, seed[1:0]});
      ev(4'h1);
      #1 check({15'h0000, force_on}, 16'h0001);
      watch(p * D + 8, 1);
      check({15'h0000, c >= (p - 2) * D && c <= (p + 1) * D + 2}, 16'h0001);
      check({14'h0000, rreq, wk}, 16'h0002);
      rd(WWDT_ADDR_RESET);
      check(d & 16'h0010, 16'h0010);
      wr(WWDT_ADDR_RESET, 16'h0000);
      rd(WWDT_ADDR_RESET);
      check(d & 16'h0010, 16'h0000);
    end
    wr(WWDT_ADDR_CONFIG, 16'h03E0);
    repeat (4) begin
      ev(4'h1);
      watch(40, 0);
      check(16'(c), 16'h0028);
    end
    wr(WWDT_ADDR_CONFIG, 16'h00C0);
    watch(200, 0);
    check({force_on, 7'h00, 8'(c)}, 16'h00C8);
    wr(WWDT_ADDR_RESET, 16'h0020);
    watch(200, 1);
    check({14'h0000, rreq, force_on}, 16'h0003);
    wr(WWDT_ADDR_CONFIG, 16'h00E0);
    for (int k = 0; k < 2; k++) begin
      ps_idle <= k[0];
      ev(4'h2);
      rd(WWDT_ADDR_RESET);
      check(d & 16'h000C, k ? 16'h0004 : 16'h0008);
      watch(200, 1);
      check({6'h00, rreq, wk, 8'(c > 50)}, 16'h0101);
      wr(WWDT_ADDR_RESET, 16'h0000);
    end
    ps_idle <= 1'b0;
    ev(4'h2);
    watch(40, 0);
    ev(4'h8);
    watch(200, 1);
    check({6'h00, rreq, wk, 8'(c > 50)}, 16'h0201);
    wr(WWDT_ADDR_CONFIG, 16'h00A0);
    ev(4'h2);
    watch(200, 0);
    check(16'(c), 16'h00C8);
    ev(4'h8);
    watch(200, 1);
    check({14'h0000, rreq, wk}, 16'h0002);
    for (int w = 0; w < 4; w++) begin
      wr(WWDT_ADDR_CONFIG, {6'h00, w[1:0], 8'h60});
      ev(4'h4);
      repeat ((thr[w] + 3) * D) @(posedge core_clk);
      ev(4'h1);
      watch(6, 0);
      check(16'(c), 16'h0006);
      repeat (2 * D) @(posedge core_clk);
      ev(4'h4);
      repeat ((thr[w] - 3) * D) @(posedge core_clk);
      ev(4'h1);
      watch(6, 1);
      check({15'h0000, rreq}, 16'h0001);
    end
    results();
  end
endmodule
`default_nettype wire

// ---- dv/wwdt_chk.sv ----
// Assertion checker for the watchdog top level
`default_nettype none
module wwdt_chk
  import wwdt_pkg::*;
#(
  parameter int DIV = LOW_POWER_RC_OSCILLATOR_DIV
) (
  // Clock and inputs
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        power_save_instruction,
  // Outputs
  input wire logic [15:0] reg_rdata,
  input wire logic        wdt_reset_req,
  input wire logic        wdt_wake,
  input wire logic        timeout_flag
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  req_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req)
    else $error("reset request too long");
  wake_pulse_a: assert property (wdt_wake |=> !wdt_wake && !wdt_reset_req)
    else $error("wake too long");
  req_flag_a: assert property ((wdt_reset_req || wdt_wake) |->
    (timeout_flag || $past(timeout_flag))) else $error("event without flag");
  flag_sticky_a: assert property ($fell(timeout_flag) |->
    ($past(reg_wr) && $past(reg_addr) == WWDT_ADDR_RESET)) else $error("flag dropped");
  flag_cause_a: assert property ($rose(timeout_flag) |->
    ##[0:2] (wdt_reset_req || wdt_wake)) else $error("flag without event");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside slot");
  unmapped_read_a: assert property (($past(reg_rd) && $past(reg_addr) > WWDT_ADDR_COUNT)
    |-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  sleep_quiet_a: assert property (power_save_instruction |=> !wdt_wake [*3])
    else $error("wake right after sleep entry");
endmodule

bind wwdt_top wwdt_chk #(.DIV(DIV)) u_wwdt_chk (
  .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .power_save_instruction(power_save_instruction),
  .reg_rdata(reg_rdata), .wdt_reset_req(wdt_reset_req), .wdt_wake(wdt_wake),
  .timeout_flag(timeout_flag)
);
`default_nettype wire

// ---- hdl/wwdt_pkg.sv ----
// Package of constants and types for the windowed watchdog timer
`default_nettype none

package wwdt_pkg;

  // ----------------------------------------------------------------
  // Register map (plain register port, word index)
  // ----------------------------------------------------------------
  localparam logic [3:0] WWDT_ADDR_CONFIG = 4'h0;
  localparam logic [3:0] WWDT_ADDR_RESET  = 4'h1;
  localparam logic [3:0] WWDT_ADDR_COUNT  = 4'h2;

  // ----------------------------------------------------------------
  // Watchdog configuration word fields
  // ----------------------------------------------------------------
  localparam int CFG_POST_LSB = 0;
  localparam int CFG_POST_W   = 4;
  localparam int CFG_PRE_BIT  = 4;
  localparam int CFG_EN_LSB   = 5;
  localparam int CFG_WIN_BIT  = 7;
  localparam int CFG_WSZ_LSB  = 8;
  localparam logic [15:0] CFG_RESET_VAL = 16'h008F;

  // ----------------------------------------------------------------
  // Reset control register fields
  // ----------------------------------------------------------------
  localparam int RC_IDLE_BIT  = 2;
  localparam int RC_SLEEP_BIT = 3;
  localparam int RC_TO_BIT    = 4;
  localparam int RC_SWEN_BIT  = 5;

  // ----------------------------------------------------------------
  // Enable field codes and prescale widths
  // ----------------------------------------------------------------
  localparam logic [1:0] EN_ALWAYS = 2'h3;
  localparam logic [1:0] EN_SOFT   = 2'h2;
  localparam logic [1:0] EN_ACTIVE = 2'h1;
  localparam int PRE_SHORT_BITS = 5;
  localparam int PRE_LONG_BITS  = 7;
  localparam int CNT_W          = 22;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_KHZ = 25000;
  localparam int LOW_POWER_RC_OSCILLATOR_KHZ     = 32;
  localparam int LOW_POWER_RC_OSCILLATOR_DIV     = CORE_CLK_KHZ / LOW_POWER_RC_OSCILLATOR_KHZ;

  typedef enum logic [1:0] {
    WWDT_RUN,
    WWDT_SLEEP,
    WWDT_IDLE
  } wwdt_pwr_t;

endpackage

`default_nettype wire

// ---- hdl/wwdt_tick.sv ----
// Low-power RC oscillator tick generator for the watchdog
`default_nettype none

module wwdt_tick
  import wwdt_pkg::*;
#(
  parameter int DIV = LOW_POWER_RC_OSCILLATOR_DIV
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Control
  input  wire logic run,
  output var  logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } wwdt_tick_st_t;

  wwdt_tick_st_t s_r;
  wwdt_tick_st_t s_nxt;

  // Stopped oscillator holds its phase at zero so restarts are clean
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (!run) begin
      s_nxt.cnt = 16'h0000;
    end else if (s_r.cnt == 16'(DIV - 1)) begin
      s_nxt.cnt  = 16'h0000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

`default_nettype wire

// ---- hdl/wwdt_top.sv ----
// Windowed watchdog timer top level
//
// Implementation choices: the register addresses and the address-and-strobe port.
`default_nettype none

module wwdt_top
  import wwdt_pkg::*;
#(
  parameter int DIV = LOW_POWER_RC_OSCILLATOR_DIV
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [15:0] reg_rdata,
  // CPU events
  input  wire logic        watchdog_clear_instruction,
  input  wire logic        power_save_instruction,
  input  wire logic        power_save_idle,
  input  wire logic        clock_switch_done,
  input  wire logic        wake_event,
  // Status outputs
  output var  logic        wdt_reset_req,
  output var  logic        wdt_wake,
  output var  logic        low_power_rc_oscillator_force_on,
  output var  logic        timeout_flag
);
  typedef struct packed {
    logic [15:0] cfg;
    logic        soft_enable_bit;
    logic        timeout_flag;
    logic        sleep_bit;
    logic        idle_bit;
    wwdt_pwr_t   pwr;
    logic [CNT_W-1:0] cnt;
    logic        rst_req;
    logic        wake;
    logic        low_power_rc_oscillator_on;
    logic [15:0] rdata;
  } wwdt_st_t;

  wwdt_st_t s_r;
  wwdt_st_t s_nxt;

  logic tick;

  // ----------------------------------------------------------------
  // Oscillator tick
  // ----------------------------------------------------------------
  wwdt_tick #(
    .DIV (DIV)
  ) u_tick (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .run      (s_r.low_power_rc_oscillator_on),
    .tick     (tick)
  );

  // ----------------------------------------------------------------
  // Internal signals
  // ----------------------------------------------------------------
  localparam int PERIOD_W = CNT_W + 1;

  logic [CFG_POST_W-1:0] postscale_select;
  logic                  prescale_select;
  logic [1:0]            enable_config;
  logic                  window_disable_bit;
  logic [1:0]            window_size_select;
  logic                  awake;
  logic                  asleep;
  logic                  sleep_entry;
  logic                  pwr_exit;
  logic                  running;
  int                    pre_bits;
  logic [PERIOD_W-1:0]   period;
  logic [PERIOD_W-1:0]   last;
  logic [PERIOD_W-1:0]   win_open;
  logic [PERIOD_W-1:0]   cnt_wide;
  logic                  at_last;
  logic                  in_window;
  logic                  clear_req;
  logic                  expired;
  logic                  early_clear;
  logic                  restart;
  logic [CNT_W-1:0]      cnt_next;
  logic                  wr_cfg;
  logic                  wr_rc;
  logic [15:0]           rc_word;
  logic [15:0]           rd_word;

  // ----------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------
  always_comb begin
    postscale_select   = s_r.cfg[CFG_POST_LSB +: CFG_POST_W];
    prescale_select    = s_r.cfg[CFG_PRE_BIT];
    enable_config      = s_r.cfg[CFG_EN_LSB +: 2];
    window_disable_bit = s_r.cfg[CFG_WIN_BIT];
    window_size_select = s_r.cfg[CFG_WSZ_LSB +: 2];
  end

  // ----------------------------------------------------------------
  // Power state and enable
  // ----------------------------------------------------------------
  // Idle still counts as active for code 01; only sleep stops the count
  always_comb begin
    awake       = (s_r.pwr == WWDT_RUN);
    asleep      = (s_r.pwr == WWDT_SLEEP);
    sleep_entry = power_save_instruction && awake;
    clear_req   = watchdog_clear_instruction && awake;
    unique case (enable_config)
      EN_ALWAYS: running = 1'b1;
      EN_SOFT:   running = s_r.soft_enable_bit;
      EN_ACTIVE: running = !asleep;
      default:   running = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Period and window
  // ----------------------------------------------------------------
  // One bit wider than the counter, so the longest setting of two to
  // the 22 ticks does not wrap to zero
  always_comb begin
    if (prescale_select) begin
      pre_bits = PRE_LONG_BITS;
    end else begin
      pre_bits = PRE_SHORT_BITS;
    end
    period = PERIOD_W'(1) << (pre_bits + int'(postscale_select));
    last   = period - PERIOD_W'(1);
    // Window opens once the allowed fraction is what remains
    unique case (window_size_select)
      2'h3:    win_open = period - (period >> 2);
      2'h2:    win_open = period - (period >> 2) - (period >> 3);
      2'h1:    win_open = period >> 1;
      default: win_open = period >> 2;
    endcase
  end

  // ----------------------------------------------------------------
  // Timer events
  // ----------------------------------------------------------------
  always_comb begin
    cnt_wide    = {1'b0, s_r.cnt};
    at_last     = (cnt_wide == last);
    in_window   = (cnt_wide >= win_open);
    expired     = running && tick && at_last;
    early_clear = running && !window_disable_bit
                  && clear_req && !in_window;
    pwr_exit    = !awake && (wake_event || expired);
    restart     = clock_switch_done
                  || sleep_entry
                  || pwr_exit
                  || clear_req;
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Prescaler and postscaler form one binary chain, so a single clear
  // restarts both stages together
  always_comb begin
    if (!running || restart || expired) begin
      cnt_next = '0;
    end else if (tick) begin
      cnt_next = s_r.cnt + CNT_W'(1);
    end else begin
      cnt_next = s_r.cnt;
    end
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_comb begin
    wr_cfg                = reg_wr && (reg_addr == WWDT_ADDR_CONFIG);
    wr_rc                 = reg_wr && (reg_addr == WWDT_ADDR_RESET);
    rc_word               = 16'h0000;
    rc_word[RC_SWEN_BIT]  = s_r.soft_enable_bit;
    rc_word[RC_TO_BIT]    = s_r.timeout_flag;
    rc_word[RC_SLEEP_BIT] = s_r.sleep_bit;
    rc_word[RC_IDLE_BIT]  = s_r.idle_bit;
    unique case (reg_addr)
      WWDT_ADDR_CONFIG: rd_word = s_r.cfg;
      WWDT_ADDR_RESET:  rd_word = rc_word;
      WWDT_ADDR_COUNT:  rd_word = s_r.cnt[CNT_W-1 -: 16];
      default:          rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt         = s_r;
    s_nxt.rst_req = 1'b0;
    s_nxt.wake    = 1'b0;
    s_nxt.low_power_rc_oscillator_on = running;
    s_nxt.cnt     = cnt_next;
    // Read data stand only in the cycle after the strobe
    s_nxt.rdata   = reg_rd ? rd_word : 16'h0000;

    // Software writes come first so that a hardware set below wins
    if (wr_cfg) begin
      s_nxt.cfg = reg_wdata;
    end
    if (wr_rc) begin
      s_nxt.soft_enable_bit = reg_wdata[RC_SWEN_BIT];
      s_nxt.timeout_flag    = reg_wdata[RC_TO_BIT];
      s_nxt.sleep_bit       = reg_wdata[RC_SLEEP_BIT];
      s_nxt.idle_bit        = reg_wdata[RC_IDLE_BIT];
    end

    // Power state tracking
    if (sleep_entry) begin
      s_nxt.pwr = power_save_idle ? WWDT_IDLE : WWDT_SLEEP;
      if (power_save_idle) begin
        s_nxt.idle_bit = 1'b1;
      end else begin
        s_nxt.sleep_bit = 1'b1;
      end
    end else if (pwr_exit) begin
      s_nxt.pwr = WWDT_RUN;
    end

    if (expired) begin
      s_nxt.timeout_flag = 1'b1;
      if (awake) begin
        s_nxt.rst_req = 1'b1;
      end else begin
        s_nxt.wake = 1'b1;
      end
    end
    if (early_clear) begin
      s_nxt.rst_req      = 1'b1;
      s_nxt.timeout_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Device reset clears counts, the software enable and the flag; a
  // system that must see the flag across its own reset keeps a copy
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r     <= '0;
      s_r.cfg <= CFG_RESET_VAL;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata     = s_r.rdata;
  assign wdt_reset_req = s_r.rst_req;
  assign wdt_wake      = s_r.wake;
  assign low_power_rc_oscillator_force_on = s_r.low_power_rc_oscillator_on;
  assign timeout_flag  = s_r.timeout_flag;
endmodule

`default_nettype wire
